/* File: logic/fpc_pkg.sv */
// shared constants for the fan pwm speed controller
package fpc_pkg;
  // clock and pwm timing
  localparam int unsigned CLK_HZ          = 250000000;
  localparam int unsigned PWM_HZ          = 30;
  // duty code resolution: 8-bit code, 0 = 0 % duty, 255 = 100 % duty
  localparam int unsigned DUTY_W          = 8;
  localparam logic [7:0]  DUTY_FULL       = 8'hff;
  localparam logic [7:0]  DUTY_ZERO       = 8'h00;
  // ticks of the duty counter per pwm period (code steps)
  localparam int unsigned STEPS_PER_PWM   = 255;
  // clock cycles per duty step, rounded down so the period never runs long
  localparam int unsigned STEP_CYCLES     = CLK_HZ / (PWM_HZ * STEPS_PER_PWM);
  localparam int unsigned PRE_W           = 16;
  // start-up interval in pwm cycles
  localparam int unsigned STARTUP_PWM     = 32;
  localparam int unsigned START_W         = 6;
  // reset value of the start-up count
  localparam logic [5:0]  START_RST       = 6'h00;
endpackage

/* File: logic/fpc_tick_gen.sv */
// divider that turns clk into a one-cycle step enable and a period-start pulse
`timescale 1ns/10ps
module fpc_tick_gen #(
  parameter int unsigned STEP_CYCLES = fpc_pkg::STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clr,
  output logic            step_en,
  output logic [7:0]      phase,
  output logic            period_start
);

  typedef struct packed {
    logic [15:0] pre;
    logic [7:0]  phase;
  } fpc_tick_s;

  fpc_tick_s st_reg;
  fpc_tick_s st_next;
  logic      step_hit;

  assign step_hit = (st_reg.pre == 16'(STEP_CYCLES - 1));

  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next.pre   = 16'h0000;
      st_next.phase = 8'h00;
    end else if (step_hit) begin
      st_next.pre = 16'h0000;
      // ramp runs 0..254, wrap marks the next pwm period
      st_next.phase = (st_reg.phase == 8'hfe) ? 8'h00 : st_reg.phase + 8'h01;
    end else begin
      st_next.pre = st_reg.pre + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign step_en      = step_hit & ~clr;
  assign phase        = st_reg.phase;
  assign period_start = step_hit & ~clr & (st_reg.phase == 8'hfe);

endmodule

/* File: logic/fpc_sync.sv */
// two-flop synchroniser for one comparator level
`timescale 1ns/10ps
module fpc_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic s1;
    logic s2;
  } fpc_sync_s;

  fpc_sync_s st_reg;
  fpc_sync_s st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = din;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= {RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  assign dout = st_reg.s2;

endmodule

/* File: logic/fpc_fan_pwm.sv */
// fan pwm speed controller: start-up timer, proportional drive, auto-shutdown, flag
// Functional notes
// - pwm period from divider, nominal 30 hz
// - duty code maps linearly to 0..100 % duty
// - full drive for 32 pwm cycles after off
// - start-up at power-up, shutdown exit, auto-shutdown exit
// - start-up timer counts pwm cycles only
// - flag low while sense above full-drive level
// - flag does not latch, follows comparator
// - sense below threshold enters auto-shutdown, drive off
// - leave auto-shutdown above threshold plus hysteresis
// - shutdown input stops all, flag inactive
// - shutdown resets all internal state
// - release from shutdown runs start-up interval
// - no release above hysteresis: stay auto-shutdown
// - shutdown overrides everything, drive stays off
// - drive output is active high
// - start-up flows straight into proportional control
// - duty resampled once every pwm cycle
// - shutdown or auto-shutdown: zero duty, flag off
`timescale 1ns/10ps
module fpc_fan_pwm #(
  parameter int unsigned STEP_CYCLES = fpc_pkg::STEP_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       shutdown_low,
  input  wire logic       release_high,
  input  wire logic       below_autoshutdown,
  input  wire logic       above_as_hyst,
  input  wire logic       above_overtemp,
  input  wire logic [7:0] temp_sense_level,
  output logic            fan_drive_output,
  output logic            overtemp_flag_n,
  output logic            in_startup,
  output logic            in_autoshutdown,
  output logic            in_shutdown
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and input synchronisers

  logic [1:0] rst_pipe_reg;
  logic       rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= 2'h0;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_pipe_reg[1];

  logic shdn_s;
  logic rel_s;
  logic below_as_s;
  logic above_hys_s;
  logic above_ot_s;

  // comparators enter as single-bit levels, each through its own synchroniser
  fpc_sync #(.RST_VAL(1'b1)) u_sync_shdn (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (shutdown_low),
    .dout  (shdn_s)
  );
  fpc_sync #(.RST_VAL(1'b0)) u_sync_rel (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (release_high),
    .dout  (rel_s)
  );
  fpc_sync #(.RST_VAL(1'b1)) u_sync_as (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (below_autoshutdown),
    .dout  (below_as_s)
  );
  fpc_sync #(.RST_VAL(1'b0)) u_sync_hys (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (above_as_hyst),
    .dout  (above_hys_s)
  );
  fpc_sync #(.RST_VAL(1'b0)) u_sync_ot (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   (above_overtemp),
    .dout  (above_ot_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [3:0] {
    FPC_SHDN  = 4'h1,
    FPC_ASHDN = 4'h2,
    FPC_START = 4'h4,
    FPC_RUN   = 4'h8
  } fpc_mode_e;

  typedef struct packed {
    fpc_mode_e  mode;
    logic [5:0] start_cnt;
    logic [7:0] duty;
    logic       drive;
    logic       flag_n;
  } fpc_state_s;

  fpc_state_s st_reg;
  fpc_state_s st_next;

  logic       tick_clr;
  logic       step_en;
  logic [7:0] phase;
  logic       period_start;

  // ramp restarts with each start-up, so interval is whole pwm cycles
  assign tick_clr = (st_reg.mode == FPC_SHDN) || (st_reg.mode == FPC_ASHDN);

  fpc_tick_gen #(.STEP_CYCLES(STEP_CYCLES)) u_tick (
    .clk          (clk),
    .rst_n        (rst_sync_n),
    .clr          (tick_clr),
    .step_en      (step_en),
    .phase        (phase),
    .period_start (period_start)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_next = st_reg;
    case (st_reg.mode)
      FPC_SHDN: begin
        st_next.start_cnt = fpc_pkg::START_RST;
        st_next.duty      = fpc_pkg::DUTY_ZERO;
        if (!shdn_s && rel_s) begin
          // release only restarts the fan above the hysteresis level
          if (above_hys_s) begin
            st_next.mode = FPC_START;
          end else begin
            st_next.mode = FPC_ASHDN;
          end
        end
      end
      FPC_ASHDN: begin
        st_next.start_cnt = fpc_pkg::START_RST;
        st_next.duty      = fpc_pkg::DUTY_ZERO;
        if (above_hys_s) begin
          st_next.mode = FPC_START;
        end
      end
      FPC_START: begin
        if (period_start) begin
          if (st_reg.start_cnt == 6'(fpc_pkg::STARTUP_PWM - 1)) begin
            st_next.mode  = FPC_RUN;
            st_next.duty  = temp_sense_level;
          end else begin
            st_next.start_cnt = st_reg.start_cnt + 6'h01;
          end
        end
      end
      FPC_RUN: begin
        if (period_start) begin
          st_next.duty = temp_sense_level;
        end
      end
      default: begin
        st_next.mode = FPC_SHDN;
      end
    endcase

    // auto-shutdown from start-up or run; threshold tied low never fires
    if ((st_reg.mode == FPC_START || st_reg.mode == FPC_RUN) && below_as_s) begin
      st_next.mode      = FPC_ASHDN;
      st_next.start_cnt = fpc_pkg::START_RST;
      st_next.duty      = fpc_pkg::DUTY_ZERO;
    end
    // shutdown beats every other condition
    if (shdn_s) begin
      st_next.mode      = FPC_SHDN;
      st_next.start_cnt = fpc_pkg::START_RST;
      st_next.duty      = fpc_pkg::DUTY_ZERO;
    end

    // output decode uses the next mode so outputs drop in the entry cycle
    case (st_next.mode)
      FPC_START: begin
        st_next.drive  = 1'b1;
        st_next.flag_n = ~above_ot_s;
      end
      FPC_RUN: begin
        // 0xff is full on; compare against ramp 0..254
        st_next.drive  = (st_next.duty > phase);
        st_next.flag_n = ~above_ot_s;
      end
      default: begin
        st_next.drive  = 1'b0;
        st_next.flag_n = 1'b1;
      end
    endcase
  end

  // power-up starts in shutdown; released sense then runs start-up
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st_reg.mode      <= FPC_SHDN;
      st_reg.start_cnt <= 6'h00;
      st_reg.duty      <= 8'h00;
      st_reg.drive     <= 1'b0;
      st_reg.flag_n    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign fan_drive_output = st_reg.drive;
  assign overtemp_flag_n  = st_reg.flag_n;
  assign in_startup       = (st_reg.mode == FPC_START);
  assign in_autoshutdown  = (st_reg.mode == FPC_ASHDN);
  assign in_shutdown      = (st_reg.mode == FPC_SHDN);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_shdn_drive_off: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    shdn_s |=> !fan_drive_output && overtemp_flag_n)
    else $error("drive or flag active one cycle after shutdown");

  chk_shdn_flag_off: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_shutdown |-> overtemp_flag_n)
    else $error("flag asserted during shutdown");

  chk_ashdn_entry: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    (in_startup || st_reg.mode == FPC_RUN) && below_as_s && !shdn_s
      |=> in_autoshutdown && !fan_drive_output)
    else $error("auto-shutdown not entered");

  chk_ashdn_exit: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_autoshutdown && !shdn_s && $past(in_autoshutdown) ##0 !above_hys_s
      |=> in_autoshutdown)
    else $error("left auto-shutdown below hysteresis");

  chk_release_hold: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_shutdown && !shdn_s && rel_s && !above_hys_s |=> in_autoshutdown)
    else $error("release below hysteresis did not hold auto-shutdown");

  chk_release_start: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_shutdown && !shdn_s && rel_s && above_hys_s |=> in_startup && fan_drive_output)
    else $error("release did not start the fan");

  chk_startup_on: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_startup |-> fan_drive_output)
    else $error("drive low during start-up");

  chk_startup_count: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_startup && period_start && st_reg.start_cnt != 6'h1f && !shdn_s && !below_as_s
      |=> in_startup && st_reg.start_cnt == $past(st_reg.start_cnt) + 6'h01)
    else $error("start-up count did not advance per pwm cycle");

  chk_startup_end: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_startup && period_start && st_reg.start_cnt == 6'h1f && !shdn_s && !below_as_s
      |=> st_reg.mode == FPC_RUN)
    else $error("start-up did not hand over to run");

  chk_flag_follow: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && $past(st_reg.mode == FPC_RUN) ##0 !shdn_s && !below_as_s
      |=> overtemp_flag_n == !$past(above_ot_s))
    else $error("flag does not follow over-temperature level");

  chk_duty_hold: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && !period_start && !shdn_s && !below_as_s
      |=> $stable(st_reg.duty))
    else $error("duty changed mid pwm cycle");

  chk_pwm_wrap: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    period_start |=> phase == 8'h00)
    else $error("ramp did not wrap at period end");

  chk_ramp_restart: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    tick_clr |=> phase == 8'h00 && !period_start)
    else $error("ramp not held at start while fan is off");

  chk_start_cnt_clr: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    $rose(in_startup) |-> st_reg.start_cnt == fpc_pkg::START_RST)
    else $error("start-up entered with a stale count");

  chk_shdn_clear: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_shutdown |-> st_reg.start_cnt == fpc_pkg::START_RST
      && st_reg.duty == fpc_pkg::DUTY_ZERO)
    else $error("internal state not cleared in shutdown");

  chk_ashdn_quiet: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_autoshutdown |-> !fan_drive_output && overtemp_flag_n
      && st_reg.duty == fpc_pkg::DUTY_ZERO)
    else $error("drive, flag or duty active in auto-shutdown");

  chk_run_sample: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && period_start && !shdn_s && !below_as_s
      |=> st_reg.duty == $past(temp_sense_level))
    else $error("duty not resampled at period start");

  chk_full_duty: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && st_reg.duty == fpc_pkg::DUTY_FULL && !period_start
      && !shdn_s && !below_as_s |=> fan_drive_output)
    else $error("full duty code did not hold drive on");

  chk_zero_duty: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && st_reg.duty == fpc_pkg::DUTY_ZERO && !period_start
      && !shdn_s && !below_as_s |=> !fan_drive_output)
    else $error("zero duty code drove the fan");

  chk_pwm_compare: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    st_reg.mode == FPC_RUN && !period_start && !shdn_s && !below_as_s
      |=> fan_drive_output == ($past(st_reg.duty) > $past(phase)))
    else $error("drive does not follow duty against ramp");

  chk_startup_flag: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    in_startup && !shdn_s && !below_as_s
      |=> overtemp_flag_n == !$past(above_ot_s))
    else $error("flag does not follow over-temperature in start-up");

  chk_drive_modes: assert property (
    @(posedge clk) disable iff (!rst_sync_n)
    fan_drive_output |-> in_startup || st_reg.mode == FPC_RUN)
    else $error("drive high outside start-up and run");

endmodule

/* File: test/fpc_fan_model.sv */
// fan behind its external power switch: spins up once the drive is held on
`timescale 1ns/10ps
module fpc_fan_model #(
  parameter int unsigned SPIN_CYCLES = 8
) (
  input  wire logic clk,
  input  wire logic drive_on,
  output logic      spinning
);
  int unsigned on_count;

  initial on_count = 0;

  // a high drive closes the switch; any low level clears the count and stops spinning at once
  always @(posedge clk) begin
    if (drive_on) begin
      if (on_count < SPIN_CYCLES) begin
        on_count <= on_count + 1;
      end
    end else begin
      on_count <= 0;
    end
  end

  assign spinning = (on_count >= SPIN_CYCLES);
endmodule

/* File: test/fan_pwm_speed_controller_tb_top.sv */
// self-checking bench for the fan pwm controller mode and flag behaviour
`timescale 1ns/10ps
module fan_pwm_speed_controller_tb_top;
  logic       clk;
  logic       rst_n;
  logic       sd;
  logic       rel;
  logic       below;
  logic       hyst;
  logic       ot;
  logic [7:0] level;
  logic       drive;
  logic       flag_n;
  logic       st;
  logic       as_m;
  logic       sd_m;
  logic       spin;
  int         num_errors;
  int         samples_checked;

  // short divider so 32 start-up periods fit the run
  localparam int TB_STEP   = 2;
  localparam int PWM_LEN   = int'(fpc_pkg::STEPS_PER_PWM) * TB_STEP;
  localparam int START_LEN = int'(fpc_pkg::STARTUP_PWM) * PWM_LEN;

  fpc_fan_pwm #(.STEP_CYCLES(TB_STEP)) u_dut (
    .clk                (clk),
    .rst_n              (rst_n),
    .shutdown_low       (sd),
    .release_high       (rel),
    .below_autoshutdown (below),
    .above_as_hyst      (hyst),
    .above_overtemp     (ot),
    .temp_sense_level   (level),
    .fan_drive_output   (drive),
    .overtemp_flag_n    (flag_n),
    .in_startup         (st),
    .in_autoshutdown    (as_m),
    .in_shutdown        (sd_m)
  );

  fpc_fan_model u_fan (
    .clk      (clk),
    .drive_on (drive),
    .spinning (spin)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic chk_int(input string name, input int exp, input int got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
    end
  endtask

  task automatic finish_test;
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // overtemp held high throughout: shutdown must still keep the flag off
  task automatic t_reset;
    chk("in_shutdown", 1'b1, sd_m);
    chk("drive", 1'b0, drive);
    chk("flag_n", 1'b1, flag_n);
  endtask

  // release while sense is below threshold plus hysteresis
  task automatic t_release_low;
    sd = 1'b0;
    rel = 1'b1;
    step(3);
    chk("in_autoshutdown", 1'b1, as_m);
    chk("in_startup", 1'b0, st);
    chk("drive", 1'b0, drive);
  endtask

  task automatic t_restart;
    hyst = 1'b1;
    step(3);
    chk("in_startup", 1'b1, st);
    chk("drive", 1'b1, drive);
    chk("flag_n", 1'b0, flag_n);
    step(8);
    chk("spinning", 1'b1, spin);
    ot = 1'b0;
    step(3);
    chk("flag_n", 1'b1, flag_n);
    chk("drive", 1'b1, drive);
  endtask

  // auto-shutdown cuts into start-up, exit needs the hysteresis comparator
  task automatic t_autoshut;
    ot = 1'b1;
    hyst = 1'b0;
    below = 1'b1;
    step(3);
    chk("in_autoshutdown", 1'b1, as_m);
    chk("drive", 1'b0, drive);
    chk("flag_n", 1'b1, flag_n);
    below = 1'b0;
    step(3);
    chk("in_autoshutdown", 1'b1, as_m);
    hyst = 1'b1;
    step(3);
    chk("in_startup", 1'b1, st);
    chk("drive", 1'b1, drive);
  endtask

  task automatic t_shutdown;
    sd = 1'b1;
    rel = 1'b0;
    step(3);
    chk("in_shutdown", 1'b1, sd_m);
    chk("drive", 1'b0, drive);
    chk("flag_n", 1'b1, flag_n);
    chk("in_startup", 1'b0, st);
    sd = 1'b0;
    rel = 1'b1;
    step(3);
    chk("in_startup", 1'b1, st);
    chk("drive", 1'b1, drive);
  endtask

  // one pwm period of drive-high cycles; new code applies from the next period
  task automatic run_window(input logic [7:0] next_level, input int exp);
    int hi;
    hi = 0;
    level = next_level;
    repeat (PWM_LEN) begin
      if (drive === 1'b1) begin
        hi++;
      end
      step(1);
    end
    chk_int("drive_high_cycles", exp, hi);
  endtask

  // start-up from the last release runs out into proportional control
  task automatic t_run;
    int n;
    n = 0;
    below = 1'b0;
    while (st === 1'b1 && n < START_LEN + 8) begin
      n++;
      step(1);
    end
    chk_int("startup_cycles", START_LEN, n);
    chk("in_startup", 1'b0, st);
    chk("in_autoshutdown", 1'b0, as_m);
    run_window(8'h40, int'(8'h80) * TB_STEP);
    run_window(8'hff, int'(8'h40) * TB_STEP);
    run_window(8'h00, int'(8'hff) * TB_STEP);
    run_window(8'h80, int'(8'h00) * TB_STEP);
    chk("flag_n", 1'b0, flag_n);
    ot = 1'b0;
    step(3);
    chk("flag_n", 1'b1, flag_n);
  endtask

  // reset in mid-run: back to power-up state, then start-up again
  task automatic t_midreset;
    rst_n = 1'b0;
    step(1);
    chk("in_shutdown", 1'b1, sd_m);
    chk("drive", 1'b0, drive);
    rst_n = 1'b1;
    step(2);
    chk("in_shutdown", 1'b1, sd_m);
    step(3);
    chk("in_startup", 1'b1, st);
    chk("drive", 1'b1, drive);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    num_errors = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    sd = 1'b1;
    rel = 1'b0;
    below = 1'b0;
    hyst = 1'b0;
    ot = 1'b1;
    level = 8'h80;
    step(12);
    rst_n = 1'b1;
    step(6);
    t_reset();
    t_release_low();
    t_restart();
    t_autoshut();
    t_shutdown();
    t_run();
    t_midreset();
    finish_test();
  end

  // start-up of 32 short periods dominates: about 18400 cycles in all
  initial begin
    #120000;
    num_errors++;
    finish_test();
  end
endmodule
